//--- design/fcp_pkg.sv
`default_nettype none
package fcp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int BUSY_TIME_NS   = 1000;   // Internal power-up or reset processing
  localparam int BUSY_CYC       = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRQ_PULSE_NS   = 200;    // Width of a pulse-mode interrupt
  localparam int IRQ_PULSE_CYC  = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 9;

  // ----------------------------------------------------------------
  // Widths and data path
  // ----------------------------------------------------------------
  localparam int ADDR_W         = 11;
  localparam int DATA_W         = 16;
  localparam int FIFO_DEPTH     = 16;
  localparam logic [15:0] EMPTY_FILL = 16'h0000;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam logic [10:0] ATTR_CFG_BASE  = 11'h200;  // Attribute space above: config regs
  localparam logic [10:0] IO_DATA_PORT   = 11'h000;  // I/O port holding the data register
  localparam logic [2:0]  TF_DATA_INDEX  = 3'h0;     // Task-file data register
  localparam int          IO_PORT_MSB    = 3;

  // Register region codes handed to the core
  localparam logic [2:0] RGN_NONE     = 3'h0;
  localparam logic [2:0] RGN_INFO     = 3'h1;
  localparam logic [2:0] RGN_CONFIG   = 3'h2;
  localparam logic [2:0] RGN_IOPORT   = 3'h3;
  localparam logic [2:0] RGN_TASKFILE = 3'h4;
  localparam logic [2:0] RGN_ALTREG   = 3'h5;
  localparam logic [2:0] RGN_COMMON   = 3'h6;

  // Personality, one-hot
  typedef enum logic [2:0] {
    FCP_MEM = 3'b001,
    FCP_IO  = 3'b010,
    FCP_IDE = 3'b100
  } fcp_mode_t;

endpackage : fcp_pkg
`default_nettype wire

//--- design/fcp_stream_if.sv
`default_nettype none
interface fcp_stream_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : fcp_stream_if
`default_nettype wire

//--- design/fcp_fifo.sv
`default_nettype none
module fcp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  // Fill and drain sides
  fcp_stream_if.snk     fill,
  fcp_stream_if.src     drain
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W:0]   count_r;
  logic [PTR_W:0]   count_nxt;
  logic             notFull_r;
  wire              push = fill.valid && notFull_r;
  wire              pop  = drain.valid && drain.ready;

  // Handshake outputs
  assign fill.ready  = notFull_r;
  assign drain.valid = (count_r != '0);
  assign drain.data  = mem[rdPtr_r];
  assign count_nxt   = count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

  // Storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= fill.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr_r   <= '0;
      rdPtr_r   <= '0;
      count_r   <= '0;
      notFull_r <= 1'b1;
    end else begin
      wrPtr_r   <= wrPtr_r + PTR_W'(push);
      rdPtr_r   <= rdPtr_r + PTR_W'(pop);
      count_r   <= count_nxt;
      notFull_r <= (count_nxt != (PTR_W+1)'(DEPTH));
    end
  end

endmodule : fcp_fifo
`default_nettype wire

//--- design/fcp_host_port.sv
`default_nettype none
module fcp_host_port
  import fcp_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Host strobes and selects
  input  wire logic              hostReset,
  input  wire logic              outEnable_n,
  input  wire logic              ioRead_n,
  input  wire logic              attrSelect_n,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              card_enable_low_n,
  input  wire logic              card_enable_high_n,
  input  wire logic              taskfile_select_n,
  input  wire logic              altreg_select_n,
  // Host data bus and status pin
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOeLow,
  output logic                   dataOeHigh,
  output logic                   ready_busy_n,
  // Core control and status
  input  wire logic              coreBusy,
  input  wire logic              ioConfigured,
  input  wire logic              irqPulseMode,
  input  wire logic              coreIrq,
  // Core register read port
  output logic                   regReq,
  output logic [2:0]             regRegion,
  output logic [ADDR_W-1:0]      regIndex,
  output logic [2:0]             personality,
  input  wire logic [DATA_W-1:0] regRdData,
  // Core data stream toward the host
  input  wire logic [DATA_W-1:0] coreData,
  input  wire logic              coreValid,
  output logic                   coreReady
);

  // ----------------------------------------------------------------
  // Byte-lane steering
  // ----------------------------------------------------------------
  // Returns {oeHigh, oeLow, data} for a source word and the enables
  function automatic logic [17:0] laneSteer(input logic [15:0] w, input logic ceLo_n,
                                            input logic ceHi_n, input logic a0);
    logic [17:0] r;
    r = 18'h00000;
    if (!ceLo_n && !ceHi_n) begin
      r = {2'b11, w};                             // Word on all lines
    end else if (!ceLo_n) begin
      r = {2'b01, 8'h00, (a0 ? w[15:8] : w[7:0])}; // Even or odd on low lane
    end else if (!ceHi_n) begin
      r = {2'b10, w[15:8], 8'h00};                 // Odd byte on high lane
    end
    return r;
  endfunction : laneSteer

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fcp_mode_t         mode_r;
  fcp_mode_t         mode_nxt;
  logic [CNT_W-1:0]  busyCnt_r;
  logic [CNT_W-1:0]  busyCnt_nxt;
  logic              holdHigh_r;
  logic              hostReset_r;
  logic [CNT_W-1:0]  pulseCnt_r;
  logic              coreIrq_r;
  logic              readActive_r;
  logic [DATA_W-1:0] dataWord_r;
  logic [DATA_W-1:0] dataOut_r;
  logic              dataOeLow_r;
  logic              dataOeHigh_r;
  logic              readyPin_r;
  logic              regReq_r;
  logic [2:0]        regRegion_r;
  logic [ADDR_W-1:0] regIndex_r;

  fcp_stream_if #(.WIDTH(DATA_W)) fillIf ();
  fcp_stream_if #(.WIDTH(DATA_W)) drainIf ();

  // ----------------------------------------------------------------
  // Buffer between core and host data reads
  // ----------------------------------------------------------------
  assign fillIf.data  = coreData;
  assign fillIf.valid = coreValid;

  fcp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .fill     (fillIf),
    .drain    (drainIf)
  );

  // ----------------------------------------------------------------
  // Ready/busy and personality
  // ----------------------------------------------------------------
  // Busy while the reset pin is high (unless held high since power-up) and after it drops
  wire resetFall  = hostReset_r && !hostReset;
  wire holdHigh   = holdHigh_r && hostReset;
  wire busyPhase  = !holdHigh && (busyCnt_r != '0);
  wire busyDone   = !holdHigh && (busyCnt_r == CNT_W'(1));

  assign busyCnt_nxt = holdHigh                  ? '0 :
                       (hostReset || resetFall)  ? CNT_W'(BUSY_CYC) :
                       (busyCnt_r != '0)         ? busyCnt_r - CNT_W'(1) :
                       busyCnt_r;

  // IDE strap taken as processing ends; I/O once the core says it is configured
  assign mode_nxt = busyDone ? (!outEnable_n ? FCP_IDE : FCP_MEM) :
                    (mode_r == FCP_IDE) ? FCP_IDE :
                    (ioConfigured ? FCP_IO : FCP_MEM);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busyCnt_r   <= CNT_W'(BUSY_CYC);
      holdHigh_r  <= 1'b1;
      hostReset_r <= 1'b0;
      mode_r      <= FCP_MEM;
    end else begin
      busyCnt_r   <= busyCnt_nxt;
      holdHigh_r  <= holdHigh;
      hostReset_r <= hostReset;
      mode_r      <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin shaping
  // ----------------------------------------------------------------
  // Pulse counter loads on a rising core request; the pin follows one edge later
  wire irqRise   = coreIrq && !coreIrq_r;
  wire pulseLow  = (pulseCnt_r != '0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      coreIrq_r  <= 1'b0;
      pulseCnt_r <= '0;
    end else begin
      coreIrq_r  <= coreIrq;
      if (irqRise && irqPulseMode && mode_r == FCP_IO) begin
        pulseCnt_r <= CNT_W'(IRQ_PULSE_CYC);
      end else if (pulseLow) begin
        pulseCnt_r <= pulseCnt_r - CNT_W'(1);
      end
    end
  end

  // Pin level per personality
  logic readyPin_nxt;
  always_comb begin
    readyPin_nxt = 1'b1;
    if (holdHigh) begin
      readyPin_nxt = 1'b1;
    end else if (busyPhase) begin
      readyPin_nxt = 1'b0;
    end else begin
      case (mode_r)
        FCP_IO:  readyPin_nxt = irqPulseMode ? !pulseLow : !coreIrq;
        FCP_IDE: readyPin_nxt = coreIrq;
        default: readyPin_nxt = !coreBusy;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  wire cardSel   = !card_enable_low_n || !card_enable_high_n;
  wire attrCfg   = (addr_in >= ATTR_CFG_BASE);
  wire [2:0] attrRegion = attrCfg ? RGN_CONFIG : RGN_INFO;
  wire ioPortHit = (addr_in[ADDR_W-1:IO_PORT_MSB+1] == IO_DATA_PORT[ADDR_W-1:IO_PORT_MSB+1]);

  // Memory: attribute select high is common data, low is attribute space
  wire memRead   = !outEnable_n && cardSel;
  wire [2:0] memRegion = attrSelect_n ? RGN_COMMON : attrRegion;
  // I/O: output-enable reaches attribute space only, I/O read the ports
  wire ioAttrRd  = !outEnable_n && cardSel && !attrSelect_n;
  wire ioPortRd  = !ioRead_n && cardSel && !attrSelect_n && ioPortHit;
  // IDE: chip selects pick task file or alternate registers
  wire tfRead    = !ioRead_n && !taskfile_select_n;
  wire altRead   = !ioRead_n && !altreg_select_n;
  wire [2:0] taskfile_index = addr_in[2:0];

  logic       readActive;
  logic [2:0] region;
  always_comb begin
    readActive = 1'b0;
    region     = RGN_NONE;
    case (mode_r)
      FCP_IO: begin
        readActive = ioAttrRd || ioPortRd;
        region     = ioAttrRd ? attrRegion : RGN_IOPORT;
      end
      FCP_IDE: begin
        readActive = tfRead || altRead;
        region     = tfRead ? RGN_TASKFILE : RGN_ALTREG;
      end
      default: begin
        readActive = memRead;
        region     = memRegion;
      end
    endcase
    if (busyPhase) begin
      readActive = 1'b0;
    end
  end

  // Data word source: the stream for common data, I/O data port and task-file data
  wire isData    = (region == RGN_COMMON) ||
                   (region == RGN_IOPORT && addr_in[IO_PORT_MSB:0] == IO_DATA_PORT[3:0]) ||
                   (region == RGN_TASKFILE && taskfile_index == TF_DATA_INDEX);
  wire readStart = readActive && !readActive_r;
  wire [DATA_W-1:0] streamWord = drainIf.valid ? drainIf.data : EMPTY_FILL;
  wire [DATA_W-1:0] srcWord = !isData ? regRdData :
                              (readStart ? streamWord : dataWord_r);

  // Pop one word at the first strobe cycle; the held copy serves the rest
  assign drainIf.ready = readStart && isData;

  // IDE: task-file bytes on low lane, data words on both lanes
  wire ideByte = (mode_r == FCP_IDE) && !(region == RGN_TASKFILE &&
                 taskfile_index == TF_DATA_INDEX);
  wire [17:0] steered = ideByte ? {2'b01, 8'h00, srcWord[7:0]} :
                        (mode_r == FCP_IDE) ? {2'b11, srcWord} :
                        laneSteer(srcWord, card_enable_low_n,
                                  card_enable_high_n, addr_in[0]);

  // Bus drive registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readActive_r <= 1'b0;
      dataWord_r   <= '0;
      dataOut_r    <= '0;
      dataOeLow_r  <= 1'b0;
      dataOeHigh_r <= 1'b0;
      readyPin_r   <= 1'b0;
    end else begin
      readActive_r <= readActive;
      dataWord_r   <= (readStart && isData) ? streamWord : dataWord_r;
      dataOut_r    <= readActive ? steered[15:0] : '0;
      dataOeLow_r  <= readActive && steered[16];
      dataOeHigh_r <= readActive && steered[17];
      readyPin_r   <= readyPin_nxt;
    end
  end

  // Register request toward the core
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regReq_r    <= 1'b0;
      regRegion_r <= RGN_NONE;
      regIndex_r  <= '0;
    end else begin
      regReq_r    <= readStart && !isData;
      regRegion_r <= readActive ? region : RGN_NONE;
      regIndex_r  <= (mode_r == FCP_IDE) ? {8'h00, taskfile_index} : addr_in;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dataOut      = dataOut_r;
  assign dataOeLow    = dataOeLow_r;
  assign dataOeHigh   = dataOeHigh_r;
  assign ready_busy_n = readyPin_r;
  assign regReq       = regReq_r;
  assign regRegion    = regRegion_r;
  assign regIndex     = regIndex_r;
  assign personality  = mode_r;
  assign coreReady    = fillIf.ready;

endmodule : fcp_host_port
`default_nettype wire

//--- verification/fcp_host_port_asserts.sv
`default_nettype none
module fcp_host_port_asserts
  import fcp_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Host strobes and status pin
  input wire logic       hostReset,
  input wire logic       outEnable_n,
  input wire logic       ioRead_n,
  input wire logic       attrSelect_n,
  input wire logic       card_enable_low_n,
  input wire logic       card_enable_high_n,
  input wire logic       dataOeLow,
  input wire logic       dataOeHigh,
  input wire logic       ready_busy_n,
  // Core side
  input wire logic       irqPulseMode,
  input wire logic       coreIrq,
  input wire logic       regReq,
  input wire logic [2:0] personality
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Memory-mode output-enable strobe once the card is ready
  wire logic memRd = personality == FCP_MEM && ready_busy_n && !outEnable_n;
  wire logic isIo  = personality == FCP_IO;
  wire logic isIde = personality == FCP_IDE;

  busy_after_reset_a: assert property ($rose(rst_n) && !hostReset |-> !ready_busy_n [*8])
    else $error("ready pin not low after reset");
  never_busy_a: assert property ($rose(rst_n) && hostReset |=> ready_busy_n [*4])
    else $error("ready pin went low with reset pin held high");
  ide_irq_high_a: assert property (isIde && $stable(personality) && coreIrq |=> ready_busy_n)
    else $error("interrupt not high in IDE mode");
  io_irq_level_a: assert property (isIo && $stable(personality) && !irqPulseMode && coreIrq
    |=> !ready_busy_n) else $error("level interrupt not low");
  io_irq_pulse_a: assert property (isIo && irqPulseMode && $rose(coreIrq)
    |-> ##2 !ready_busy_n [*8]) else $error("pulse interrupt too short");
  oe_release_a: assert property (ioRead_n && (outEnable_n || isIde)
    |=> !dataOeLow && !dataOeHigh) else $error("lanes driven without strobe");
  word_lanes_a: assert property ((memRd && !card_enable_low_n && !card_enable_high_n) [*2]
    |=> dataOeLow && dataOeHigh) else $error("word read not on both lanes");
  odd_high_a: assert property ((memRd && card_enable_low_n && !card_enable_high_n) [*2]
    |=> dataOeHigh && !dataOeLow) else $error("high enable not on high lane");
  io_common_off_a: assert property ((isIo && !outEnable_n && attrSelect_n && ioRead_n) [*2]
    |=> !dataOeLow && !dataOeHigh) else $error("common read answered in I/O mode");
  req_pulse_a: assert property (regReq |=> !regReq)
    else $error("register request longer than one cycle");
endmodule : fcp_host_port_asserts

bind fcp_host_port fcp_host_port_asserts fcp_host_port_asserts_inst (
  .core_clk(core_clk), .rst_n(rst_n), .hostReset(hostReset), .outEnable_n(outEnable_n),
  .ioRead_n(ioRead_n), .attrSelect_n(attrSelect_n), .card_enable_low_n(card_enable_low_n),
  .card_enable_high_n(card_enable_high_n), .dataOeLow(dataOeLow), .dataOeHigh(dataOeHigh),
  .ready_busy_n(ready_busy_n), .irqPulseMode(irqPulseMode), .coreIrq(coreIrq),
  .regReq(regReq), .personality(personality)
);
`default_nettype wire

//--- verification/fcp_host_model.sv
`default_nettype none
module fcp_host_model (
  // Clock and card status
  input  wire logic        core_clk,
  input  wire logic        ready_busy_n,
  input  wire logic [2:0]  personality,
  // Host strobes, selects and address
  output var logic         outEnable_n,
  output var logic         ioRead_n,
  output var logic         attrSelect_n,
  output var logic         card_enable_low_n,
  output var logic         card_enable_high_n,
  output var logic         taskfile_select_n,
  output var logic         altreg_select_n,
  output var logic [10:0]  addr_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strapIde = 1'b0;
  // Release strobes, output enable held low when the IDE strap is set; address lines show the inverse of the last value, only the low three in IDE
  task automatic park();
    outEnable_n = !strapIde;
    {ioRead_n, attrSelect_n, card_enable_low_n, card_enable_high_n} = 4'hf;
    {taskfile_select_n, altreg_select_n} = 2'b11;
    addr_in = (personality[2] === 1'b1) ? {8'h00, ~addr_in[2:0]} : ~addr_in;
  endtask : park
  // Count busy cycles until the pin shows ready, giving up after 1000
  task automatic wait_ready(output int n);
    n = 0;
    while (ready_busy_n !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_ready
  // One read: strobe bits {oe, iord, attr, ceL, ceH, cs0, cs1}, held for two edges
  task automatic rd(input logic [6:0] s, input logic [10:0] a);
    @(negedge core_clk);
    {outEnable_n, ioRead_n, card_enable_low_n} = {s[6], s[5], s[3]};
    {card_enable_high_n, taskfile_select_n, altreg_select_n} = s[2:0];
    attrSelect_n = s[4] && !(personality[1] && !s[5]);
    addr_in = personality[2] ? {8'h00, a[2:0]} : a;
    repeat (2) @(negedge core_clk);
  endtask : rd
  initial begin
    addr_in = 11'h000;
    park();
  end
endmodule : fcp_host_model
`default_nettype wire

//--- verification/tb_fcp_host_port.sv
`default_nettype none
module tb_fcp_host_port;
  import fcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, hostReset = 1'b0, coreBusy = 1'b0;
  logic ioConfigured = 1'b0, irqPulseMode = 1'b0, coreIrq = 1'b0, coreValid = 1'b0;
  logic [15:0] regRdData = 16'h5aa5, coreData = 16'h0000, dataOut;
  logic dataOeLow, dataOeHigh, ready_busy_n, regReq, coreReady;
  logic [2:0] regRegion, personality;
  logic [10:0] regIndex, addr_in;
  logic oeN, iordN, attrN, ceLoN, ceHiN, tfN, altN;
  int fails = 0, n_checks = 0, n;

  initial forever #2 core_clk = ~core_clk;

  fcp_host_model fcp_host_model_inst (.core_clk(core_clk), .ready_busy_n(ready_busy_n),
    .personality(personality), .outEnable_n(oeN), .ioRead_n(iordN), .attrSelect_n(attrN),
    .card_enable_low_n(ceLoN), .card_enable_high_n(ceHiN), .taskfile_select_n(tfN),
    .altreg_select_n(altN), .addr_in(addr_in));
  fcp_host_port fcp_host_port_inst (.core_clk(core_clk), .rst_n(rst_n), .hostReset(hostReset),
    .outEnable_n(oeN), .ioRead_n(iordN), .attrSelect_n(attrN), .addr_in(addr_in),
    .card_enable_low_n(ceLoN), .card_enable_high_n(ceHiN), .taskfile_select_n(tfN),
    .altreg_select_n(altN), .dataOut(dataOut), .dataOeLow(dataOeLow),
    .dataOeHigh(dataOeHigh), .ready_busy_n(ready_busy_n), .coreBusy(coreBusy),
    .ioConfigured(ioConfigured), .irqPulseMode(irqPulseMode), .coreIrq(coreIrq),
    .regReq(regReq), .regRegion(regRegion), .regIndex(regIndex), .personality(personality),
    .regRdData(regRdData), .coreData(coreData), .coreValid(coreValid), .coreReady(coreReady));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Reset for 12 cycles with the card reset pin and the IDE strap at the levels given
  task automatic do_reset(input logic hr, input logic strap);
    @(negedge core_clk);
    rst_n = 1'b0;
    hostReset = hr;
    ioConfigured = 1'b0;
    fcp_host_model_inst.strapIde = strap;
    fcp_host_model_inst.park();
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
  endtask : do_reset
  // Push words until the buffer refuses
  task automatic fill(output int k);
    k = 0;
    @(negedge core_clk);
    while (coreReady === 1'b1 && k < 20) begin
      coreData = {8'hb0 + 8'(k), 8'h40 + 8'(k)};
      coreValid = 1'b1;
      k++;
      @(negedge core_clk);
    end
    coreValid = 1'b0;
  endtask : fill
  function automatic logic [15:0] word(input int j);
    return {8'hb0 + 8'(j), 8'h40 + 8'(j)};
  endfunction : word
  task automatic rd(input logic [6:0] s, input logic [10:0] a);
    fcp_host_model_inst.rd(s, a);
  endtask : rd
  task automatic idle();
    @(negedge core_clk);
    fcp_host_model_inst.park();
  endtask : idle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    do_reset(1'b1, 1'b0);
    repeat (3) @(negedge core_clk);
    check("held ready", {15'h0, ready_busy_n}, 16'h0001);
    do_reset(1'b0, 1'b0);
    fcp_host_model_inst.wait_ready(n);
    check("busy span", {15'h0, n >= BUSY_CYC && n <= BUSY_CYC + 2}, 16'h0001);
    coreBusy = 1'b1;
    repeat (3) @(negedge core_clk);
    check("core busy", {15'h0, ready_busy_n}, 16'h0000);
    coreBusy = 1'b0;
    repeat (3) @(negedge core_clk);
    check("core ready", {15'h0, ready_busy_n}, 16'h0001);
    hostReset = 1'b1;
    repeat (4) @(negedge core_clk);
    check("pin reset busy", {15'h0, ready_busy_n}, 16'h0000);
    hostReset = 1'b0;
    fcp_host_model_inst.wait_ready(n);
    check("pin reset span", {15'h0, n >= BUSY_CYC && n <= BUSY_CYC + 2}, 16'h0001);
  endtask : t_power
  task automatic t_mem();
    logic [15:0] w;
    fill(n);
    check("fifo depth", 16'(n), 16'(FIFO_DEPTH));
    for (int j = 0; j < 17; j++) begin
      w = word(j);
      case (j)
        1: rd(7'b0110111, 11'h000);
        2: rd(7'b0110111, 11'h001);
        3: rd(7'b0111011, 11'h000);
        default: rd(7'b0110011, 11'h000);
      endcase
      case (j)
        1: check("even low", {dataOeHigh, dataOeLow, 6'h0, dataOut[7:0]}, {8'h40, w[7:0]});
        2: check("odd low", {dataOeHigh, dataOeLow, 6'h0, dataOut[7:0]}, {8'h40, w[15:8]});
        3: check("odd high", {dataOeHigh, dataOeLow, 6'h0, dataOut[15:8]}, {8'h80, w[15:8]});
        16: begin
          check("empty read", dataOut, EMPTY_FILL);
          check("empty lanes", {14'h0, dataOeHigh, dataOeLow}, 16'h0003);
        end
        default: check("word read", dataOut, word(j));
      endcase
      idle();
    end
    rd(7'b0100011, 11'h210);
    check("config region", {13'h0, regRegion}, {13'h0, RGN_CONFIG});
    check("config data", dataOut, regRdData);
    idle();
    rd(7'b0100011, 11'h004);
    check("info region", {13'h0, regRegion}, {13'h0, RGN_INFO});
    check("info index", {5'h0, regIndex}, 16'h0004);
    idle();
  endtask : t_mem
  task automatic t_io();
    ioConfigured = 1'b1;
    repeat (3) @(negedge core_clk);
    check("io mode", {13'h0, personality}, {13'h0, FCP_IO});
    fill(n);
    rd(7'b1000011, 11'h000);
    check("io data", dataOut, word(0));
    idle();
    rd(7'b1000011, 11'h010);
    check("io refused", {14'h0, dataOeHigh, dataOeLow}, 16'h0000);
    idle();
    rd(7'b0110011, 11'h000);
    check("io common", {14'h0, dataOeHigh, dataOeLow}, 16'h0000);
    idle();
    rd(7'b0100011, 11'h210);
    check("io config", {13'h0, regRegion}, {13'h0, RGN_CONFIG});
    check("io config data", dataOut, regRdData);
    idle();
    coreIrq = 1'b1;
    repeat (3) @(negedge core_clk);
    check("level irq", {15'h0, ready_busy_n}, 16'h0000);
    coreIrq = 1'b0;
    irqPulseMode = 1'b1;
    repeat (3) @(negedge core_clk);
    coreIrq = 1'b1;
    n = 0;
    repeat (100) begin
      @(negedge core_clk);
      n += int'(!ready_busy_n);
    end
    check("pulse width", 16'(n), 16'(IRQ_PULSE_CYC));
    coreIrq = 1'b0;
    irqPulseMode = 1'b0;
  endtask : t_io
  task automatic t_ide();
    do_reset(1'b0, 1'b1);
    repeat (BUSY_CYC + 6) @(negedge core_clk);
    check("ide mode", {13'h0, personality}, {13'h0, FCP_IDE});
    coreIrq = 1'b1;
    repeat (3) @(negedge core_clk);
    check("ide irq", {15'h0, ready_busy_n}, 16'h0001);
    coreIrq = 1'b0;
    fill(n);
    rd(7'b0011101, 11'h003);
    check("taskfile region", {13'h0, regRegion}, {13'h0, RGN_TASKFILE});
    check("taskfile byte", {dataOeHigh, dataOeLow, 3'h0, regIndex}, 16'h4003);
    idle();
    rd(7'b0011110, 11'h006);
    check("alt region", {13'h0, regRegion}, {13'h0, RGN_ALTREG});
    idle();
    rd(7'b0011101, 11'h000);
    check("ide word", dataOut, word(0));
    check("ide lanes", {14'h0, dataOeHigh, dataOeLow}, 16'h0003);
    idle();
  endtask : t_ide

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    t_power();
    t_mem();
    t_io();
    t_ide();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    tally_and_finish();
  end
endmodule : tb_fcp_host_port
`default_nettype wire
